// [cbg_pkg.sv]
// shared constants for the board bus glue
package cbg_pkg;

  localparam int ADDR_W      = 15;
  localparam int DATA_W      = 8;
  localparam int SEL_W       = 5;
  localparam int ROM_DEPTH   = 32;
  localparam int CODE_W      = 8;
  localparam int SECTIONS    = 8;
  localparam int LOC_LSB     = 0;
  localparam int LOC_MSB     = 7;
  localparam int SEC_LSB     = 8;
  localparam int SEC_MSB     = 10;
  localparam int HIGH_LSB    = 11;
  localparam int HIGH_MSB    = 14;

  // lookup address bit positions
  localparam int A_RW        = 0;
  localparam int A_REQ       = 1;
  localparam int A_DC        = 2;
  localparam int A_ENE       = 3;
  localparam int A_MIO       = 4;

  // lookup output bit positions
  localparam int B_PORT_D_LOAD = 0;
  localparam int B_PORT_D_IN_N = 1;
  localparam int B_PORT_C_IN_N = 2;
  localparam int B_PORT_C_LOAD = 3;
  localparam int B_INT_ACK_N   = 4;
  localparam int B_RW_INV      = 5;
  localparam int B_EXT_DRIVE   = 6;
  localparam int B_EXT_RECV_N  = 7;

  // rw high = read, mio high = memory, ene high = extended, dc high = data
  function automatic logic [CODE_W-1:0] cbg_entry(input logic [SEL_W-1:0] a);
    logic [CODE_W-1:0] c;
    logic nx_io;
    c = 8'h00;
    nx_io = a[A_REQ] & ~a[A_MIO] & ~a[A_ENE];
    c[B_PORT_D_LOAD] = nx_io & a[A_DC] & ~a[A_RW];
    c[B_PORT_D_IN_N] = ~(nx_io & a[A_DC] & a[A_RW]);
    c[B_PORT_C_IN_N] = ~(nx_io & ~a[A_DC] & a[A_RW]);
    c[B_PORT_C_LOAD] = nx_io & ~a[A_DC] & ~a[A_RW];
    c[B_INT_ACK_N]   = ~(a[A_REQ] & (a[A_MIO] | ~a[A_ENE]));
    c[B_RW_INV]      = ~a[A_RW];
    c[B_EXT_DRIVE]   = a[A_REQ] & ~a[A_RW];
    c[B_EXT_RECV_N]  = ~(a[A_REQ] & a[A_RW]);
    return c;
  endfunction

endpackage

// [cbg_decode_if.sv]
// primary control lines in, secondary strobes out
`timescale 1ns/1ps
interface cbg_decode_if;
  logic [cbg_pkg::SEL_W-1:0]  sel;
  logic [cbg_pkg::CODE_W-1:0] code;
  modport user   (output sel, input code);
  modport lookup (input sel, output code);
endinterface

// [cbg_decode_rom.sv]
// 32 by 8 secondary control lookup
`timescale 1ns/1ps
module cbg_decode_rom (
  cbg_decode_if.lookup dec
);

  logic [cbg_pkg::CODE_W-1:0] rom [cbg_pkg::ROM_DEPTH];

  for (genvar gi = 0; gi < cbg_pkg::ROM_DEPTH; gi++) begin : g_entry
    assign rom[gi] = cbg_pkg::cbg_entry(cbg_pkg::SEL_W'(gi));
  end

  assign dec.code = rom[dec.sel];

endmodule // cbg_decode_rom

// [cbg_bus_glue.sv]
// processor, memory and expansion bus glue
`timescale 1ns/1ps

// Behaviour
// - processor bus tri-state enables always asserted
// - external driver enable on requested writes
// - external receiver enable low on requested reads
// - no request: external transceivers both off
// - external data bus is inverted
// - memory transceivers enabled by select and direction
// - memory side inverts back, no complement
// - address buffers drive only during request
// - request and run/wait always driven
// - dma low floats four control outputs
// - pause when dma or pause low
// - reset from switch or external reset
// - acknowledge is AND of both sources
// - internal acknowledge except extended I/O
// - secondary lines from 32x8 lookup
// - eight 256-byte sections, low byte offset
// - memory select from request, memory, high zeros
// - memory select gates memory transceivers
// - port latch load strobes on writes
// - port input enables low on reads
module cbg_bus_glue (
  input  wire logic                        clk,
  input  wire logic                        rst,
  // processor side
  input  wire logic [cbg_pkg::ADDR_W-1:0]  cpu_addr,
  input  wire logic [cbg_pkg::DATA_W-1:0]  cpu_data_out,
  output logic      [cbg_pkg::DATA_W-1:0]  cpu_data_in,
  input  wire logic                        operation_request,
  input  wire logic                        cpu_run_wait,
  input  wire logic                        cpu_read_write,
  input  wire logic                        cpu_memory_io,
  input  wire logic                        extended_or_nonextended,
  input  wire logic                        cpu_data_control,
  input  wire logic                        cpu_interrupt_acknowledge,
  input  wire logic                        cpu_write_pulse,
  output logic                             address_output_enable,
  output logic                             databus_output_enable,
  output logic                             cpu_pause_n,
  output logic                             cpu_reset,
  output logic                             cpu_interrupt_request,
  output logic                             cpu_operation_acknowledge_n,
  // board pins
  input  wire logic                        dma_n,
  input  wire logic                        pause_n,
  input  wire logic                        ext_reset_n,
  input  wire logic                        reset_switch,
  input  wire logic                        interrupt_request,
  input  wire logic                        ext_operation_acknowledge_n,
  input  wire logic                        external_operation_request,
  // buffered address bus
  output logic      [cbg_pkg::ADDR_W-1:0]  bus_addr_o,
  output logic                             bus_addr_oe,
  input  wire logic [cbg_pkg::ADDR_W-1:0]  bus_addr_i,
  // buffered control lines
  output logic                             bus_operation_request,
  output logic                             bus_run_wait,
  output logic                             bus_interrupt_acknowledge_o,
  output logic                             bus_write_pulse_o,
  output logic                             bus_read_write_o,
  output logic                             bus_memory_io_o,
  output logic                             bus_ctrl_oe,
  input  wire logic                        bus_read_write_i,
  input  wire logic                        bus_memory_io_i,
  // external data lines, active low
  output logic      [cbg_pkg::DATA_W-1:0]  external_data_lines_o,
  output logic                             external_data_lines_oe,
  input  wire logic [cbg_pkg::DATA_W-1:0]  external_data_lines_i,
  // transceiver enables
  output logic                             ext_bus_drive_enable,
  output logic                             ext_bus_receive_enable_n,
  output logic                             mem_bus_drive_enable,
  output logic                             mem_bus_receive_enable_n,
  // on-board memory
  output logic                             onboard_memory_select,
  output logic      [cbg_pkg::SECTIONS-1:0] section_select_n,
  output logic      [cbg_pkg::LOC_MSB:0]   mem_location,
  input  wire logic [cbg_pkg::DATA_W-1:0]  mem_read_data,
  output logic      [cbg_pkg::DATA_W-1:0]  mem_write_data,
  // parallel ports
  output logic                             port_d_latch_load,
  output logic                             port_c_latch_load,
  output logic                             port_d_input_enable_n,
  output logic                             port_c_input_enable_n,
  output logic                             internal_acknowledge_n
);

  // outputs stay combinational: a registered stage would stretch every
  // processor bus cycle by a clock, which the processor cannot see

  cbg_decode_if dec ();

  logic [cbg_pkg::CODE_W-1:0] code;
  logic                       high_zero;
  logic                       any_request;
  logic                       mem_hit;
  logic                       ext_drive;
  logic                       ext_recv_n;
  logic                       mem_drive;
  logic                       mem_recv_n;
  logic [2:0]                 section;
  logic [cbg_pkg::DATA_W-1:0] bus_level;

  // primary lines form the lookup address
  assign dec.sel[cbg_pkg::A_RW]    = cpu_read_write;
  assign dec.sel[cbg_pkg::A_REQ]   = operation_request;
  assign dec.sel[cbg_pkg::A_DC]    = cpu_data_control;
  assign dec.sel[cbg_pkg::A_ENE]   = extended_or_nonextended;
  assign dec.sel[cbg_pkg::A_MIO]   = cpu_memory_io;
  assign code = dec.code;

  cbg_decode_rom u_rom (
    .dec (dec)
  );

  assign address_output_enable = 1'b0;
  assign databus_output_enable = 1'b0;

  assign ext_drive  = code[cbg_pkg::B_EXT_DRIVE];
  assign ext_recv_n = code[cbg_pkg::B_EXT_RECV_N];
  assign ext_bus_drive_enable     = ext_drive;
  assign ext_bus_receive_enable_n = ext_recv_n;

  // request from processor or dma master
  assign any_request = operation_request | external_operation_request;
  assign high_zero   = ~|bus_addr_i[cbg_pkg::HIGH_MSB:cbg_pkg::HIGH_LSB];
  assign mem_hit     = any_request & bus_memory_io_i & high_zero;
  assign onboard_memory_select = mem_hit;

  assign mem_drive  = mem_hit & bus_read_write_i;
  assign mem_recv_n = ~(mem_hit & ~bus_read_write_i);
  assign mem_bus_drive_enable     = mem_drive;
  assign mem_bus_receive_enable_n = mem_recv_n;

  assign section      = bus_addr_i[cbg_pkg::SEC_MSB:cbg_pkg::SEC_LSB];
  assign mem_location = bus_addr_i[cbg_pkg::LOC_MSB:cbg_pkg::LOC_LSB];
  for (genvar gs = 0; gs < cbg_pkg::SECTIONS; gs++) begin : g_section
    assign section_select_n[gs] = ~(mem_hit & (section == 3'(gs)));
  end

  // memory data inverted onto the bus
  assign external_data_lines_o  = ext_drive ? ~cpu_data_out : ~mem_read_data;
  assign external_data_lines_oe = ext_drive | mem_drive;
  assign bus_level = external_data_lines_i;

  assign cpu_data_in    = ext_recv_n ? 8'h00 : ~bus_level;
  assign mem_write_data = mem_recv_n ? 8'h00 : ~bus_level;

  assign bus_addr_o  = cpu_addr;
  assign bus_addr_oe = operation_request;

  assign bus_operation_request = operation_request;
  assign bus_run_wait          = cpu_run_wait;

  assign bus_ctrl_oe                 = dma_n;
  assign bus_interrupt_acknowledge_o = cpu_interrupt_acknowledge;
  assign bus_write_pulse_o           = cpu_write_pulse;
  assign bus_read_write_o            = cpu_read_write;
  assign bus_memory_io_o             = cpu_memory_io;

  assign cpu_pause_n = dma_n & pause_n;

  assign cpu_reset             = reset_switch | ~ext_reset_n;
  assign cpu_interrupt_request = interrupt_request;

  assign internal_acknowledge_n = code[cbg_pkg::B_INT_ACK_N];

  // extended I/O waits for the device
  assign cpu_operation_acknowledge_n = ext_operation_acknowledge_n
                                     & internal_acknowledge_n;

  assign port_d_latch_load = code[cbg_pkg::B_PORT_D_LOAD];
  assign port_c_latch_load = code[cbg_pkg::B_PORT_C_LOAD];
  assign port_d_input_enable_n = code[cbg_pkg::B_PORT_D_IN_N];
  assign port_c_input_enable_n = code[cbg_pkg::B_PORT_C_IN_N];

  // checks, sampled on clk; the logic itself is clockless

  sequence s_req_write;
    operation_request && !cpu_read_write;
  endsequence

  sequence s_req_read;
    operation_request && cpu_read_write;
  endsequence

  sequence s_nx_io;
    operation_request && !cpu_memory_io && !extended_or_nonextended;
  endsequence

  AST_TRISTATE_HELD: assert property (
    @(posedge clk) disable iff (rst)
    !address_output_enable && !databus_output_enable)
    else $error("processor tri-state enable released");

  AST_EXT_DRIVE: assert property (
    @(posedge clk) disable iff (rst)
    ext_bus_drive_enable == (operation_request && !cpu_read_write))
    else $error("external drive enable wrong");

  AST_EXT_RECV: assert property (
    @(posedge clk) disable iff (rst)
    s_req_read |-> !ext_bus_receive_enable_n && !ext_bus_drive_enable)
    else $error("external receive not enabled on read");

  AST_EXT_IDLE: assert property (
    @(posedge clk) disable iff (rst)
    !operation_request |-> !ext_bus_drive_enable && ext_bus_receive_enable_n)
    else $error("external transceiver active without request");

  AST_EXT_INVERT: assert property (
    @(posedge clk) disable iff (rst)
    s_req_write |-> external_data_lines_oe
                    && (external_data_lines_o == ~cpu_data_out))
    else $error("external data not inverted processor data");

  AST_MEM_ENABLES: assert property (
    @(posedge clk) disable iff (rst)
    (mem_bus_drive_enable == (onboard_memory_select && bus_read_write_i))
    && (mem_bus_receive_enable_n == !(onboard_memory_select && !bus_read_write_i)))
    else $error("memory transceiver enables wrong");

  AST_MEM_NO_COMPLEMENT: assert property (
    @(posedge clk) disable iff (rst)
    !mem_bus_receive_enable_n && !ext_bus_drive_enable
    |-> mem_write_data == ~external_data_lines_i)
    else $error("memory write data complemented");

  AST_ADDR_FLOAT: assert property (
    @(posedge clk) disable iff (rst)
    bus_addr_oe == operation_request)
    else $error("address buffer enable wrong");

  AST_CTRL_ALWAYS: assert property (
    @(posedge clk) disable iff (rst)
    (bus_operation_request == operation_request)
    && (bus_run_wait == cpu_run_wait))
    else $error("request or run/wait not passed through");

  AST_DMA_FLOAT: assert property (
    @(posedge clk) disable iff (rst)
    bus_ctrl_oe == dma_n)
    else $error("control outputs driven during dma");

  AST_PAUSE: assert property (
    @(posedge clk) disable iff (rst)
    cpu_pause_n == (dma_n && pause_n))
    else $error("pause not the OR of both requests");

  AST_RESET: assert property (
    @(posedge clk) disable iff (rst)
    cpu_reset == (reset_switch || !ext_reset_n))
    else $error("processor reset wrong");

  AST_ACK_MERGE: assert property (
    @(posedge clk) disable iff (rst)
    cpu_operation_acknowledge_n
      == (ext_operation_acknowledge_n && internal_acknowledge_n))
    else $error("acknowledge merge wrong");

  AST_ACK_EXT_IO: assert property (
    @(posedge clk) disable iff (rst)
    !cpu_memory_io && extended_or_nonextended |-> internal_acknowledge_n)
    else $error("internal acknowledge on extended I/O");

  AST_ACK_MEM: assert property (
    @(posedge clk) disable iff (rst)
    operation_request && cpu_memory_io |-> !internal_acknowledge_n)
    else $error("no internal acknowledge on memory cycle");

  AST_ONBOARD_MEMORY_SELECT: assert property (
    @(posedge clk) disable iff (rst)
    onboard_memory_select == ((operation_request || external_operation_request)
      && bus_memory_io_i && (bus_addr_i[14:11] == 4'h0)))
    else $error("memory select wrong");

  AST_SECTION: assert property (
    @(posedge clk) disable iff (rst)
    onboard_memory_select |-> $onehot(~section_select_n)
      && !section_select_n[bus_addr_i[10:8]])
    else $error("section select wrong");

  AST_MEM_GATED: assert property (
    @(posedge clk) disable iff (rst)
    !onboard_memory_select |-> !mem_bus_drive_enable && mem_bus_receive_enable_n)
    else $error("memory transceiver on without select");

  AST_PORT_LOAD: assert property (
    @(posedge clk) disable iff (rst)
    s_nx_io ##0 (!cpu_read_write)
    |-> (port_d_latch_load == cpu_data_control)
        && (port_c_latch_load == !cpu_data_control))
    else $error("port latch load strobe wrong");

  AST_PORT_IN: assert property (
    @(posedge clk) disable iff (rst)
    s_nx_io ##0 cpu_read_write
    |-> (port_d_input_enable_n == !cpu_data_control)
        && (port_c_input_enable_n == cpu_data_control)
        && !port_d_latch_load && !port_c_latch_load)
    else $error("port input enable wrong");

  AST_NO_LATENCY: assert property (
    @(posedge clk) disable iff (rst)
    $rose(operation_request) && !cpu_read_write |-> ext_bus_drive_enable)
    else $error("drive enable lags request");

  AST_IRQ_PASS: assert property (
    @(posedge clk) disable iff (rst)
    cpu_interrupt_request == interrupt_request)
    else $error("interrupt request not passed through");

  AST_LOCATION: assert property (
    @(posedge clk) disable iff (rst)
    mem_location == bus_addr_i[7:0])
    else $error("memory location not the low address byte");

  AST_PORT_IDLE: assert property (
    @(posedge clk) disable iff (rst)
    !operation_request |-> !port_d_latch_load && !port_c_latch_load
      && port_d_input_enable_n && port_c_input_enable_n)
    else $error("port strobe without request");

endmodule // cbg_bus_glue

// [cbg_far_side.sv]
// far side model: board memory array, expansion device and data line levels
`timescale 1ns/1ps
module cbg_far_side (
  input  wire logic       clk,
  input  wire logic       dsg_oe,
  input  wire logic [7:0] dsg_lines,
  input  wire logic       dev_drive,
  input  wire logic [7:0] dev_value,
  input  wire logic       ack_req,
  input  wire logic [3:0] ack_delay,
  input  wire logic [7:0] sec_sel_n,
  input  wire logic [7:0] loc,
  input  wire logic       mem_rcv_n,
  input  wire logic [7:0] mem_wdata,
  output logic      [7:0] mem_rdata,
  output logic      [7:0] lines,
  output logic            ack_n
);
  logic [7:0] mem_reg [0:2047];
  logic [7:0] last_reg;
  logic [3:0] cnt_reg;
  logic [2:0] sec;

  always_comb begin
    sec = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (sec_sel_n[i] === 1'b0) sec = i[2:0];
    end
  end
  assign mem_rdata = mem_reg[{sec, loc}];

  // device data goes out inverted
  // released lines show the inverse of the last level: no pull-up to lean on
  always_comb begin
    if (dsg_oe === 1'b1) lines = dsg_lines;
    else if (dev_drive) lines = ~dev_value;
    else lines = ~last_reg;
  end

  assign ack_n = !(ack_req && cnt_reg >= ack_delay);

  always_ff @(posedge clk) begin
    last_reg <= $isunknown(lines) ? 8'h55 : lines;
    if (mem_rcv_n === 1'b0) mem_reg[{sec, loc}] <= mem_wdata;
    cnt_reg <= ack_req ? cnt_reg + 4'h1 : 4'h0;
  end
endmodule // cbg_far_side

// [cbg_bus_glue_tb.sv]
// self-checking bench for the board bus glue
`timescale 1ns/1ps
module cbg_bus_glue_tb;
  logic clk, rst, operation_request, cpu_run_wait, cpu_read_write, cpu_memory_io;
  logic extended_or_nonextended, cpu_data_control, cpu_interrupt_acknowledge, cpu_write_pulse;
  logic address_output_enable, databus_output_enable, cpu_pause_n, cpu_reset;
  logic cpu_interrupt_request, cpu_operation_acknowledge_n, dma_n, pause_n, ext_reset_n;
  logic reset_switch, interrupt_request, ext_operation_acknowledge_n, external_operation_request;
  logic bus_addr_oe, bus_operation_request, bus_run_wait, bus_interrupt_acknowledge_o;
  logic bus_write_pulse_o, bus_read_write_o, bus_memory_io_o, bus_ctrl_oe, bus_read_write_i;
  logic bus_memory_io_i, external_data_lines_oe, ext_bus_drive_enable, ext_bus_receive_enable_n;
  logic mem_bus_drive_enable, mem_bus_receive_enable_n, onboard_memory_select;
  logic port_d_latch_load, port_c_latch_load, port_d_input_enable_n, port_c_input_enable_n;
  logic internal_acknowledge_n, dma_rw, dma_mio, dev_drive;
  logic [14:0] cpu_addr, bus_addr_o, bus_addr_i, dma_addr;
  logic [7:0]  cpu_data_out, cpu_data_in, external_data_lines_o, external_data_lines_i;
  logic [7:0]  section_select_n, mem_location, mem_read_data, mem_write_data, dev_value;
  logic [3:0]  ack_delay;
  int          fail_count, check_count, cycles;

  cbg_bus_glue cbg_bus_glue_i (.*);
  cbg_far_side cbg_far_side_i (
    .clk, .dsg_oe(external_data_lines_oe), .dsg_lines(external_data_lines_o), .dev_drive,
    .dev_value, .ack_req(operation_request & extended_or_nonextended & ~cpu_memory_io),
    .ack_delay, .sec_sel_n(section_select_n), .loc(mem_location),
    .mem_rcv_n(mem_bus_receive_enable_n), .mem_wdata(mem_write_data),
    .mem_rdata(mem_read_data), .lines(external_data_lines_i),
    .ack_n(ext_operation_acknowledge_n));

  // bench plays the dma master on released address and control lines
  assign bus_addr_i       = bus_addr_oe ? bus_addr_o : dma_addr;
  assign bus_read_write_i = bus_ctrl_oe ? bus_read_write_o : dma_rw;
  assign bus_memory_io_i  = bus_ctrl_oe ? bus_memory_io_o : dma_mio;

  always #12.5 clk = ~clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic tick();
    @(posedge clk);
    #2;
  endtask

  task automatic bus(input logic rq, rw, mio, ene, dc, input logic [14:0] a,
                     input logic [7:0] d);
    operation_request = rq;
    cpu_read_write = rw;
    cpu_memory_io = mio;
    extended_or_nonextended = ene;
    cpu_data_control = dc;
    cpu_addr = a;
    cpu_data_out = d;
    #1;
  endtask

  task automatic t_static();
    for (int i = 0; i < 4; i++) begin
      tick();
      {ext_reset_n, reset_switch} = i[1:0];
      {cpu_run_wait, interrupt_request} = i[1:0];
      {cpu_write_pulse, cpu_interrupt_acknowledge} = i[1:0];
      #1;
      chkb(cpu_reset, i[0] | !i[1], "reset");
      chkb(cpu_interrupt_request, i[0], "irq");
      chkb(address_output_enable | databus_output_enable, 1'b0, "cpu oe");
      chkb(bus_run_wait, i[1], "run wait");
      chkb(bus_interrupt_acknowledge_o, i[0], "interrupt_acknowledge copy");
      chkb(bus_write_pulse_o, i[1], "write pulse copy");
      chkb(bus_read_write_o, 1'b1, "rw copy");
      chkb(bus_memory_io_o, 1'b0, "mio copy");
    end
    reset_switch = 1'b0;
    ext_reset_n = 1'b1;
  endtask

  task automatic t_sweep();
    logic rw, rq, dc, ene, mio, nx, ms;
    ack_delay = 4'h0;
    for (int i = 0; i < 32; i++) begin
      {mio, ene, dc, rq, rw} = i[4:0];
      nx = rq & !mio & !ene;
      ms = rq & mio;
      tick();
      bus(rq, rw, mio, ene, dc, 15'h0100, 8'h00);
      chkb(ext_bus_drive_enable, rq & !rw, "ext drive");
      chkb(ext_bus_receive_enable_n, !(rq & rw), "ext recv");
      chkb(bus_addr_oe, rq, "addr oe");
      chkb(bus_operation_request, rq, "req copy");
      chkb(port_d_latch_load, nx & dc & !rw, "d load");
      chkb(port_c_latch_load, nx & !dc & !rw, "c load");
      chkb(port_d_input_enable_n, !(nx & dc & rw), "d in");
      chkb(port_c_input_enable_n, !(nx & !dc & rw), "c in");
      chkb(internal_acknowledge_n, !(rq & (mio | !ene)), "int ack");
      chkb(cpu_operation_acknowledge_n, !rq, "ack merge");
      chkb(onboard_memory_select, ms, "mem select");
      chkb(mem_bus_drive_enable, ms & rw, "mem drive");
      chkb(mem_bus_receive_enable_n, !(ms & !rw), "mem recv");
      chk(section_select_n, ms ? 8'hFD : 8'hFF, "section");
    end
  endtask

  task automatic t_mem();
    logic [14:0] a;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      a = {4'h0, i[2:0], i[0] ? 8'hFF : 8'(i * 19)};
      d = 8'h5A ^ 8'(i * 29);
      tick();
      bus(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, a, d);
      chk(external_data_lines_o, ~d, "bus data");
      chk(section_select_n, ~(8'h01 << i), "section");
      chk(mem_location, a[7:0], "location");
      chkb(bus_addr_o === a, 1'b1, "addr out");
    end
    // each high address bit alone must miss the board, or location 0 is hit
    for (int j = 0; j < 4; j++) begin
      tick();
      bus(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 15'h0800 << j, 8'hFF);
      chkb(onboard_memory_select, 1'b0, "high bits");
      chkb(mem_bus_receive_enable_n, 1'b1, "no write");
    end
    for (int i = 0; i < 8; i++) begin
      a = {4'h0, i[2:0], i[0] ? 8'hFF : 8'(i * 19)};
      tick();
      bus(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, a, 8'h00);
      chk(cpu_data_in, 8'h5A ^ 8'(i * 29), "readback");
    end
  endtask

  task automatic t_ext();
    int n;
    tick();
    ack_delay = 4'h3;
    dev_value = 8'h5A;
    dev_drive = 1'b1;
    bus(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 15'h0042, 8'h00);
    chk(cpu_data_in, 8'h5A, "ext read");
    chkb(internal_acknowledge_n, 1'b1, "no int ack");
    n = 0;
    while (cpu_operation_acknowledge_n !== 1'b0 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n), 8'h03, "ack wait");
    tick();
    dev_drive = 1'b0;
    bus(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 15'h0042, 8'h00);
    chkb(cpu_operation_acknowledge_n, 1'b1, "ack drop");
  endtask

  task automatic t_dma();
    tick();
    // dma only lowered while request is low
    dma_n = 1'b0;
    dma_addr = 15'h0733;
    dma_rw = 1'b0;
    dma_mio = 1'b1;
    external_operation_request = 1'b1;
    dev_value = 8'hC3;
    dev_drive = 1'b1;
    #1;
    chkb(bus_ctrl_oe, 1'b0, "ctl float");
    chkb(cpu_pause_n, 1'b0, "dma pause");
    chkb(bus_run_wait, cpu_run_wait, "rw driven");
    chkb(onboard_memory_select, 1'b1, "dma sel");
    chk(mem_write_data, 8'hC3, "dma wdata");
    tick();
    dma_rw = 1'b1;
    dev_drive = 1'b0;
    #1;
    chkb(mem_bus_drive_enable, 1'b1, "dma rd");
    chk(external_data_lines_i, 8'h3C, "dma rdata");
    tick();
    external_operation_request = 1'b0;
    #1;
    chkb(onboard_memory_select, 1'b0, "no ext req");
    tick();
    dma_n = 1'b1;
    pause_n = 1'b0;
    #1;
    chkb(cpu_pause_n, 1'b0, "pause");
    chkb(bus_ctrl_oe, 1'b1, "ctl drive");
    tick();
    pause_n = 1'b1;
    #1;
    chkb(cpu_pause_n, 1'b1, "run");
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    fail_count = 0;
    check_count = 0;
    cycles = 0;
    cpu_run_wait = 1'b1;
    cpu_interrupt_acknowledge = 1'b0;
    cpu_write_pulse = 1'b0;
    dma_n = 1'b1;
    pause_n = 1'b1;
    ext_reset_n = 1'b1;
    reset_switch = 1'b0;
    interrupt_request = 1'b0;
    external_operation_request = 1'b0;
    dma_addr = 15'h7FFF;
    dma_rw = 1'b1;
    dma_mio = 1'b0;
    dev_drive = 1'b0;
    dev_value = 8'h00;
    ack_delay = 4'h0;
    bus(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 15'h0000, 8'h00);
    repeat (16) @(posedge clk);
    #2;
    rst = 1'b0;
    t_static();
    t_sweep();
    t_mem();
    t_ext();
    t_dma();
    print_verdict();
  end
endmodule // cbg_bus_glue_tb
